// ---- verilog/tmc_core.v ----
// Purpose: torque-mode control: reference selection, cyclic interpolation, target-reached flag
// Assumes: all inputs synchronous to mclk_i; sync pulse marks each synchronisation period
// Notes: homing, analog filtering and lost process-data handling live elsewhere
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "tmc_map.vh"
module tmc_core (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire [7:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [15:0] reg_rdata_o,
   input wire pdo_valid_i,
   input wire signed [15:0] pdo_setpoint_i,
   input wire signed [15:0] pdo_offset_i,
   input wire sync_i,
   input wire op_enabled_i,
   input wire signed [15:0] filtered_analog_input_voltage_i,
   input wire signed [15:0] measured_torque_current_i,
   output reg signed [15:0] commanded_torque_current_o,
   output wire torque_active_o,
   output wire auto_enable_o,
   output wire target_reached_o,
   output wire irq_o
);
   ////////////////////////////////////////////////////////////////////////////
   // registers
   reg [7:0] operating_mode_selector_r;
   reg signed [15:0] torque_setpoint_r;
   reg [15:0] torque_ramp_rate_r;
   reg [15:0] torque_ramp_shape_r;
   reg signed [15:0] torque_additive_offset_r;
   reg [1:0] cyclic_interpolation_select_r;
   reg [0:0] ctrl_r;
   reg [15:0] rated_stall_current_r;
   reg [15:0] control_loop_interval_r;
   reg [2:0] irq_stat_r;
   reg [2:0] irq_mask_r;
   reg [2:0] irq_stat_nxt;
   reg reached_r;
   reg [16:0] hold_cnt_r;
   reg [15:0] loop_cnt_r;
   reg signed [15:0] pdo_set_r;
   reg signed [15:0] pdo_off_r;
   reg signed [15:0] cyc_start_r;
   reg signed [15:0] cyc_end_r;
   reg signed [15:0] cyc_step_r;
   reg signed [15:0] cyc_ref_r;
   reg [15:0] ticks_in_period_r;
   reg [15:0] tick_cnt_r;
   reg signed [15:0] ref_nxt;
   wire loop_tick;
   wire run;
   wire signed [15:0] ramp_out;
   wire signed [16:0] err;
   wire [16:0] abs_err;
   wire [31:0] win_prod;
   wire [31:0] win_div;
   wire [16:0] win_lim;
   wire in_window;
   wire mode_torque;
   wire mode_analog;
   wire mode_cyclic;

   // decode the mode selector; used by several paths
   function [2:0] tmc_mode_dec;
      input [7:0] m;
      begin
         tmc_mode_dec = {m == `TMC_MODE_CYCLIC, m == `TMC_MODE_ANALOG, m == `TMC_MODE_TORQUE};
      end
   endfunction

   assign mode_torque = tmc_mode_dec(operating_mode_selector_r) == 3'h1;
   assign mode_analog = tmc_mode_dec(operating_mode_selector_r) == 3'h2;
   assign mode_cyclic = tmc_mode_dec(operating_mode_selector_r) == 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // register port
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         operating_mode_selector_r <= 8'h00;
         torque_setpoint_r <= 16'h0000;
         torque_ramp_rate_r <= `TMC_RST_RAMP;
         torque_ramp_shape_r <= 16'h0000;
         torque_additive_offset_r <= 16'h0000;
         cyclic_interpolation_select_r <= `TMC_INTERP_NONE;
         ctrl_r <= 1'h0;
         rated_stall_current_r <= `TMC_RST_STALL;
         control_loop_interval_r <= `TMC_RST_LOOPDIV;
         irq_mask_r <= 3'h0;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `TMC_ADDR_MODE: begin
               operating_mode_selector_r <= reg_wdata_i[7:0];
            end
            `TMC_ADDR_SETPT: begin
               torque_setpoint_r <= reg_wdata_i;
            end
            `TMC_ADDR_RAMP: begin
               torque_ramp_rate_r <= reg_wdata_i;
            end
            `TMC_ADDR_SHAPE: begin
               torque_ramp_shape_r <= reg_wdata_i;
            end
            `TMC_ADDR_OFFSET: begin
               torque_additive_offset_r <= reg_wdata_i;
            end
            `TMC_ADDR_INTERP: begin
               cyclic_interpolation_select_r <= reg_wdata_i[1:0];
            end
            `TMC_ADDR_CTRL: begin
               ctrl_r <= reg_wdata_i[0:0];
            end
            `TMC_ADDR_IRQ_MASK: begin
               irq_mask_r <= reg_wdata_i[2:0];
            end
            `TMC_ADDR_STALL: begin
               rated_stall_current_r <= reg_wdata_i;
            end
            `TMC_ADDR_LOOPDIV: begin
               // zero would stretch the loop tick to one per 65536 cycles, so hold at least one
               control_loop_interval_r <= (reg_wdata_i == 16'h0000) ? 16'h0001 : reg_wdata_i;
            end
            default: begin
            end
         endcase
      end
   end

   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `TMC_ADDR_MODE: reg_rdata_o <= {8'h00, operating_mode_selector_r};
            `TMC_ADDR_SETPT: reg_rdata_o <= torque_setpoint_r;
            `TMC_ADDR_RAMP: reg_rdata_o <= torque_ramp_rate_r;
            `TMC_ADDR_SHAPE: reg_rdata_o <= torque_ramp_shape_r;
            `TMC_ADDR_OFFSET: reg_rdata_o <= torque_additive_offset_r;
            `TMC_ADDR_INTERP: reg_rdata_o <= {14'h0000, cyclic_interpolation_select_r};
            `TMC_ADDR_CTRL: reg_rdata_o <= {15'h0000, ctrl_r};
            `TMC_ADDR_STATUS: reg_rdata_o <= {13'h0000, torque_active_o, run, reached_r};
            `TMC_ADDR_IRQ_STAT: reg_rdata_o <= {13'h0000, irq_stat_r};
            `TMC_ADDR_IRQ_MASK: reg_rdata_o <= {13'h0000, irq_mask_r};
            `TMC_ADDR_STALL: reg_rdata_o <= rated_stall_current_r;
            `TMC_ADDR_TORQUE: reg_rdata_o <= commanded_torque_current_o;
            `TMC_ADDR_LOOPDIV: reg_rdata_o <= control_loop_interval_r;
            default: reg_rdata_o <= 16'h0000;
         endcase
      end else begin
         reg_rdata_o <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // enable and loop tick
   // analog mode enables itself; torque and cyclic modes need profile enable and software enable
   assign run = mode_analog | ((mode_torque | mode_cyclic) & op_enabled_i & ctrl_r[`TMC_CTRL_ENABLE]);
   assign auto_enable_o = mode_analog;
   assign torque_active_o = run;

   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         loop_cnt_r <= 16'h0000;
      end else if (loop_cnt_r >= control_loop_interval_r - 16'h0001) begin
         loop_cnt_r <= 16'h0000;
      end else begin
         loop_cnt_r <= loop_cnt_r + 16'h0001;
      end
   end
   assign loop_tick = (loop_cnt_r >= control_loop_interval_r - 16'h0001);

   ////////////////////////////////////////////////////////////////////////////
   // cyclic stream: latch process data, apply at sync
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pdo_set_r <= 16'h0000;
         pdo_off_r <= 16'h0000;
      end else if (pdo_valid_i) begin
         // only process data carries the stream; a lost frame keeps the last value
         pdo_set_r <= pdo_setpoint_i;
         pdo_off_r <= pdo_offset_i;
      end
   end

   // count loop ticks per sync period so the step for the next period is known
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tick_cnt_r <= 16'h0000;
         ticks_in_period_r <= 16'h0001;
      end else if (sync_i) begin
         tick_cnt_r <= 16'h0000;
         ticks_in_period_r <= (tick_cnt_r == 16'h0000) ? 16'h0001 : tick_cnt_r;
      end else if (loop_tick && tick_cnt_r != 16'hFFFF) begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
   end

   // divider only at sync; a loop-rate step keeps the per-tick path cheap
   wire signed [16:0] cyc_span;
   wire signed [16:0] new_target;
   assign new_target = {pdo_set_r[15], pdo_set_r} + {pdo_off_r[15], pdo_off_r};
   assign cyc_span = new_target - {cyc_ref_r[15], cyc_ref_r};

   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cyc_start_r <= 16'h0000;
         cyc_end_r <= 16'h0000;
         cyc_step_r <= 16'h0000;
         cyc_ref_r <= 16'h0000;
      end else if (sync_i) begin
         cyc_start_r <= cyc_ref_r;
         cyc_end_r <= new_target[15:0];
         if (cyclic_interpolation_select_r == `TMC_INTERP_LINEAR) begin
            cyc_step_r <= $signed(cyc_span[15:0]) / $signed({1'b0, ticks_in_period_r[14:0]});
         end else begin
            cyc_ref_r <= new_target[15:0];
            cyc_step_r <= 16'h0000;
         end
      end else if (loop_tick && cyclic_interpolation_select_r == `TMC_INTERP_LINEAR) begin
         // straight line from period-start value; stop at the new setpoint
         if ((cyc_step_r >= 0 && cyc_ref_r + cyc_step_r >= cyc_end_r) ||
             (cyc_step_r < 0 && cyc_ref_r + cyc_step_r <= cyc_end_r)) begin
            cyc_ref_r <= cyc_end_r;
         end else begin
            cyc_ref_r <= cyc_ref_r + cyc_step_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reference selection and ramp
   always @* begin
      ref_nxt = 16'h0000;
      if (mode_analog) begin
         ref_nxt = filtered_analog_input_voltage_i;
      end else if (mode_torque) begin
         ref_nxt = torque_setpoint_r;
      end else if (mode_cyclic) begin
         ref_nxt = cyc_ref_r;
      end
   end

   // cyclic mode bypasses the ramp: the master owns the trajectory
   tmc_ramp u_ramp (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .tick_i(loop_tick),
      .run_i(run & ~mode_cyclic),
      .target_i(ref_nxt),
      .rate_i(torque_ramp_rate_r),
      .shape_i(torque_ramp_shape_r),
      .value_o(ramp_out)
   );

   // no speed clamp here by design; the reference passes unlimited
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         commanded_torque_current_o <= 16'h0000;
      end else if (!run) begin
         commanded_torque_current_o <= 16'h0000;
      end else if (mode_cyclic) begin
         commanded_torque_current_o <= cyc_ref_r;
      end else begin
         commanded_torque_current_o <= ramp_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // target reached
   assign err = {commanded_torque_current_o[15], commanded_torque_current_o} -
                {measured_torque_current_i[15], measured_torque_current_i};
   assign abs_err = err[16] ? -err : err;
   assign win_prod = rated_stall_current_r * `TMC_WIN_PCT;
   // integer division rounds the window down, so it never grows past the limit
   assign win_div = win_prod / 32'h00000064;
   assign win_lim = win_div[16:0];
   assign in_window = run && (abs_err < win_lim);

   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hold_cnt_r <= 17'h00000;
         reached_r <= 1'b0;
      end else if (!in_window) begin
         hold_cnt_r <= 17'h00000;
         reached_r <= 1'b0;
      end else if (hold_cnt_r >= `TMC_REACH_CYC - 1) begin
         reached_r <= 1'b1;
      end else begin
         hold_cnt_r <= hold_cnt_r + 17'h00001;
      end
   end
   assign target_reached_o = reached_r;

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: set wins over write-one-to-clear
   reg reached_d_r;
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reached_d_r <= 1'b0;
      end else begin
         reached_d_r <= reached_r;
      end
   end

   always @* begin
      irq_stat_nxt = irq_stat_r;
      if (reg_wr_i && reg_addr_i == `TMC_ADDR_IRQ_STAT) begin
         irq_stat_nxt = irq_stat_r & ~reg_wdata_i[2:0];
      end
      if (reached_r && !reached_d_r) begin
         irq_stat_nxt[`TMC_IRQ_REACHED] = 1'b1;
      end
      if (sync_i && mode_cyclic) begin
         irq_stat_nxt[`TMC_IRQ_SYNC] = 1'b1;
      end
      if (!reached_r && reached_d_r) begin
         irq_stat_nxt[`TMC_IRQ_LEFT] = 1'b1;
      end
   end

   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_stat_r <= 3'h0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
      end
   end
   assign irq_o = |(irq_stat_r & irq_mask_r);
endmodule

// ---- verilog/tmc_map.vh ----
// Purpose: constants of the torque-mode control block
// Assumes: included by its bare name
// Notes: offsets are word addresses on the plain register port
`ifndef TMC_MAP_VH
`define TMC_MAP_VH
// register offsets
`define TMC_ADDR_MODE 8'h00
`define TMC_ADDR_SETPT 8'h01
`define TMC_ADDR_RAMP 8'h02
`define TMC_ADDR_SHAPE 8'h03
`define TMC_ADDR_OFFSET 8'h04
`define TMC_ADDR_INTERP 8'h05
`define TMC_ADDR_CTRL 8'h06
`define TMC_ADDR_STATUS 8'h07
`define TMC_ADDR_IRQ_STAT 8'h08
`define TMC_ADDR_IRQ_MASK 8'h09
`define TMC_ADDR_STALL 8'h0A
`define TMC_ADDR_TORQUE 8'h0B
`define TMC_ADDR_LOOPDIV 8'h0C
// mode selector values
`define TMC_MODE_TORQUE 8'h04
`define TMC_MODE_CYCLIC 8'h0A
`define TMC_MODE_ANALOG 8'h9B
// interpolation sub-mode values
`define TMC_INTERP_NONE 2'h0
`define TMC_INTERP_LINEAR 2'h1
// control bits
`define TMC_CTRL_ENABLE 0
// status bits
`define TMC_STAT_REACHED 0
`define TMC_STAT_ENABLED 1
`define TMC_STAT_ACTIVE 2
// irq bits
`define TMC_IRQ_REACHED 0
`define TMC_IRQ_SYNC 1
`define TMC_IRQ_LEFT 2
// reset values
`define TMC_RST_LOOPDIV 16'h007D
`define TMC_RST_STALL 16'h0400
`define TMC_RST_RAMP 16'hFFFF
// timing: reached window hold time
`define TMC_REACH_TIME_NS 1000000
`define TMC_CLK_NS 8
`define TMC_REACH_CYC (`TMC_REACH_TIME_NS / `TMC_CLK_NS)
// window width in percent of stall current
`define TMC_WIN_PCT 5
`endif

// ---- verilog/tmc_ramp.v ----
// Purpose: slope limiter stepping toward a target once per loop tick
// Assumes: signed 16-bit torque values
// Notes: shape 0 is a linear slope; other shapes pass the target directly
`timescale 1ns/1ps
module tmc_ramp (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire tick_i,
   input wire run_i,
   input wire signed [15:0] target_i,
   input wire [15:0] rate_i,
   input wire [15:0] shape_i,
   output reg signed [15:0] value_o
);
   wire signed [17:0] diff;
   wire signed [17:0] rate_s;
   reg signed [15:0] value_nxt;

   assign diff = {{2{target_i[15]}}, target_i} - {{2{value_o[15]}}, value_o};
   assign rate_s = {2'h0, rate_i};

   always @* begin
      value_nxt = value_o;
      if (!run_i) begin
         value_nxt = 16'h0000;
      end else if (tick_i) begin
         // a zero rate would freeze the output, so treat it as unlimited
         if (shape_i != 16'h0000 || rate_i == 16'h0000) begin
            value_nxt = target_i;
         end else if (diff > rate_s) begin
            value_nxt = value_o + rate_i;
         end else if (diff < -rate_s) begin
            value_nxt = value_o - rate_i;
         end else begin
            value_nxt = target_i;
         end
      end
   end

   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         value_o <= 16'h0000;
      end else begin
         value_o <= value_nxt;
      end
   end
endmodule

// ---- tb/tmc_properties.sv ----
// Purpose: port-level checks of the torque-mode control block
// Assumes: bound to tmc_core, one clock, reset high
// Notes: reached timing allows two cycles of slack for the registered flag
`timescale 1ns/1ps
`include "tmc_map.vh"
module tmc_properties (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire [7:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [15:0] reg_rdata_o,
   input wire pdo_valid_i,
   input wire signed [15:0] pdo_setpoint_i,
   input wire signed [15:0] pdo_offset_i,
   input wire sync_i,
   input wire signed [15:0] measured_torque_current_i,
   input wire signed [15:0] commanded_torque_current_o,
   input wire torque_active_o,
   input wire auto_enable_o,
   input wire target_reached_o,
   input wire irq_o
);
   localparam int REACH = `TMC_REACH_CYC;
   reg [7:0] mode_r;
   reg [1:0] interp_r;
   reg [2:0] mask_r;
   reg signed [15:0] sum_r;
   reg [16:0] run_r;
   wire [7:0] wmode = reg_wdata_i[7:0];
   wire signed [16:0] err = commanded_torque_current_o - measured_torque_current_i;
   // widest window is 5% of a full-scale stall current, so beyond it nothing may count as reached
   wire big_err = (err > 17'sd3276) || (err < -17'sd3276);
   ////////////////////////////////////////
   always @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_r <= 8'h00;
         interp_r <= 2'h0;
         mask_r <= 3'h0;
         sum_r <= 16'sh0000;
         run_r <= 17'h00000;
      end else begin
         if (reg_wr_i && reg_addr_i == `TMC_ADDR_MODE) mode_r <= wmode;
         if (reg_wr_i && reg_addr_i == `TMC_ADDR_INTERP) interp_r <= reg_wdata_i[1:0];
         if (reg_wr_i && reg_addr_i == `TMC_ADDR_IRQ_MASK) mask_r <= reg_wdata_i[2:0];
         if (pdo_valid_i) sum_r <= pdo_setpoint_i + pdo_offset_i;
         run_r <= !torque_active_o ? 17'h00000 : (run_r == 17'h1FFFF ? run_r : run_r + 17'h00001);
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("read data outside slot");
   unmapped_rd_a: assert property (reg_rd_i && reg_addr_i > `TMC_ADDR_LOOPDIV |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   mode_rd_a: assert property (reg_rd_i && reg_addr_i == `TMC_ADDR_MODE |=> reg_rdata_o[7:0] == mode_r)
      else $error("mode readback wrong");
   auto_en_a: assert property (reg_wr_i && reg_addr_i == `TMC_ADDR_MODE |=>
      auto_enable_o == ($past(wmode) == `TMC_MODE_ANALOG)) else $error("self enable wrong");
   irq_level_a: assert property (reg_rd_i && reg_addr_i == `TMC_ADDR_IRQ_STAT |=>
      $past(irq_o) == ((reg_rdata_o[2:0] & mask_r) != 3'h0)) else $error("irq level wrong");
   reach_time_a: assert property ($rose(target_reached_o) |-> run_r >= REACH - 2)
      else $error("reached too early");
   reach_idle_a: assert property (!torque_active_o |=> !target_reached_o) else $error("reached while idle");
   big_err_a: assert property (big_err |=> !target_reached_o) else $error("reached outside window");
   sync_apply_a: assert property (mode_r == `TMC_MODE_CYCLIC && interp_r == `TMC_INTERP_NONE && torque_active_o
      && sync_i |-> ##2 commanded_torque_current_o == sum_r) else $error("setpoint not applied at sync");
endmodule
bind tmc_core tmc_properties u_props (.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
   .reg_rdata_o, .pdo_valid_i, .pdo_setpoint_i, .pdo_offset_i, .sync_i, .measured_torque_current_i,
   .commanded_torque_current_o, .torque_active_o, .auto_enable_o, .target_reached_o, .irq_o);

// ---- tb/tmc_fbus_master.sv ----
// Purpose: fieldbus master sending one process-data setpoint per sync period
// Assumes: period longer than the control loop interval
// Notes: data lines are inverted once taken so stale values never look valid
`timescale 1ns/1ps
module tmc_fbus_master (
   input wire mclk_i,
   output logic pdo_valid_o,
   output logic signed [15:0] pdo_setpoint_o,
   output logic signed [15:0] pdo_offset_o,
   output logic sync_o
);
   initial begin
      pdo_valid_o = 1'b0;
      pdo_setpoint_o = 16'sh0000;
      pdo_offset_o = 16'sh0000;
      sync_o = 1'b0;
   end
   ////////////////////////////////////////
   // each setpoint goes out once and is never resent
   task automatic send(input logic signed [15:0] sp, input logic signed [15:0] off, input int period);
      @(posedge mclk_i);
      pdo_valid_o <= 1'b1;
      pdo_setpoint_o <= sp;
      pdo_offset_o <= off;
      @(posedge mclk_i);
      pdo_valid_o <= 1'b0;
      pdo_setpoint_o <= ~sp;
      pdo_offset_o <= ~off;
      sync_o <= 1'b1;
      @(posedge mclk_i);
      sync_o <= 1'b0;
      repeat (period - 3) @(posedge mclk_i);
   endtask
endmodule

// ---- tb/tb.sv ----
// Purpose: self-checking bench of the torque-mode control block
// Assumes: loop interval set to 4 cycles, sync period 20 cycles
// Notes: the reached test runs the full 1 ms hold time
`timescale 1ns/1ps
`include "tmc_map.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic op_en = 1'b0;
   logic signed [15:0] ana = 16'sh0000;
   logic signed [15:0] meas = 16'sh0000;
   wire [15:0] rdata;
   wire pv, sy, act, aen, reached, irq;
   wire signed [15:0] psp, poff, cmd;
   int fail_count = 0;
   int checks_done = 0;
   tmc_core DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .pdo_valid_i(pv), .pdo_setpoint_i(psp), .pdo_offset_i(poff),
      .sync_i(sy), .op_enabled_i(op_en), .filtered_analog_input_voltage_i(ana), .measured_torque_current_i(meas),
      .commanded_torque_current_o(cmd), .torque_active_o(act), .auto_enable_o(aen), .target_reached_o(reached),
      .irq_o(irq));
   tmc_fbus_master M (.mclk_i(mclk_i), .pdo_valid_o(pv), .pdo_setpoint_o(psp), .pdo_offset_o(poff), .sync_o(sy));
   initial forever #4 mclk_i = ~mclk_i;
   ////////////////////////////////////////
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   task automatic t_regs;
      logic [15:0] v;
      rd_reg(`TMC_ADDR_RAMP, v);
      `CHK(v, `TMC_RST_RAMP)
      rd_reg(`TMC_ADDR_STALL, v);
      `CHK(v, `TMC_RST_STALL)
      rd_reg(`TMC_ADDR_LOOPDIV, v);
      `CHK(v, `TMC_RST_LOOPDIV)
      rd_reg(8'h3F, v);
      `CHK(v, 16'h0000)
      rd_reg(`TMC_ADDR_STATUS, v);
      `CHK(v[0], 1'b0)
      $display("test regs done");
   endtask
   task automatic t_torque;
      wr_reg(`TMC_ADDR_LOOPDIV, 16'h0004);
      wr_reg(`TMC_ADDR_RAMP, 16'h000A);
      wr_reg(`TMC_ADDR_MODE, {8'h00, `TMC_MODE_TORQUE});
      wr_reg(`TMC_ADDR_CTRL, 16'h0001);
      op_en <= 1'b1;
      wr_reg(`TMC_ADDR_SETPT, 16'h0032);
      wait_cyc(8);
      `CHK(cmd > 16'sd0 && cmd < 16'sd50, 1'b1)
      wait_cyc(30);
      `CHK(cmd, 16'sd50)
      `CHK(act, 1'b1)
      wr_reg(`TMC_ADDR_SHAPE, 16'h0001);
      wr_reg(`TMC_ADDR_SETPT, 16'hFFE2);
      wait_cyc(10);
      `CHK(cmd, -16'sd30)
      @(posedge mclk_i);
      op_en <= 1'b0;
      wait_cyc(3);
      `CHK(act, 1'b0)
      $display("test torque done");
   endtask
   task automatic t_analog;
      logic [15:0] v;
      wr_reg(`TMC_ADDR_MODE, {8'h00, `TMC_MODE_ANALOG});
      ana <= -16'sd77;
      wait_cyc(10);
      `CHK(aen, 1'b1)
      `CHK(act, 1'b1)
      `CHK(cmd, -16'sd77)
      rd_reg(`TMC_ADDR_MODE, v);
      `CHK(v, {8'h00, `TMC_MODE_ANALOG})
      $display("test analog done");
   endtask
   task automatic t_cyclic;
      logic [15:0] v;
      wr_reg(`TMC_ADDR_INTERP, {14'h0000, `TMC_INTERP_NONE});
      wr_reg(`TMC_ADDR_MODE, {8'h00, `TMC_MODE_CYCLIC});
      op_en <= 1'b1;
      wr_reg(`TMC_ADDR_IRQ_MASK, 16'h0002);
      wr_reg(`TMC_ADDR_IRQ_STAT, 16'h0007);
      M.send(16'sd300, -16'sd50, 20);
      #1;
      `CHK(cmd, 16'sd250)
      `CHK(irq, 1'b1)
      rd_reg(`TMC_ADDR_IRQ_STAT, v);
      `CHK(v[1], 1'b1)
      wr_reg(`TMC_ADDR_IRQ_STAT, 16'h0002);
      wait_cyc(1);
      `CHK(irq, 1'b0)
      wr_reg(`TMC_ADDR_IRQ_MASK, 16'h0000);
      M.send(-16'sd120, 16'sd0, 20);
      #1;
      `CHK(cmd, -16'sd120)
      `CHK(irq, 1'b0)
      $display("test cyclic done");
   endtask
   task automatic t_linear;
      int mids;
      logic signed [15:0] prev;
      mids = 0;
      prev = cmd;
      wr_reg(`TMC_ADDR_INTERP, {14'h0000, `TMC_INTERP_LINEAR});
      M.send(16'sd0, 16'sd0, 20);
      M.send(16'sd0, 16'sd0, 20);
      fork
         M.send(16'sd100, 16'sd0, 20);
         repeat (20) begin
            @(posedge mclk_i);
            #1;
            if (cmd != prev && cmd > 16'sd0 && cmd < 16'sd100) mids++;
            prev = cmd;
         end
      join
      `CHK(mids >= 3, 1'b1)
      wait_cyc(10);
      `CHK(cmd, 16'sd100)
      $display("test linear done");
   endtask
   task automatic t_reach;
      logic [15:0] v;
      wr_reg(`TMC_ADDR_INTERP, {14'h0000, `TMC_INTERP_NONE});
      wr_reg(`TMC_ADDR_IRQ_STAT, 16'h0007);
      meas <= 16'sd400;
      M.send(16'sd400, 16'sd0, 20);
      wait_cyc(125010);
      `CHK(reached, 1'b1)
      rd_reg(`TMC_ADDR_STATUS, v);
      `CHK(v[0], 1'b1)
      @(posedge mclk_i);
      meas <= 16'sd460;
      wait_cyc(2);
      `CHK(reached, 1'b0)
      rd_reg(`TMC_ADDR_IRQ_STAT, v);
      `CHK(v[0], 1'b1)
      `CHK(v[2], 1'b1)
      @(posedge mclk_i);
      meas <= -16'sd3000;
      wait_cyc(2);
      `CHK(reached, 1'b0)
      $display("test reach done");
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      t_regs;
      t_torque;
      t_analog;
      t_cyclic;
      t_linear;
      t_reach;
      conclude;
   end
   // about 125k cycles of tests, so this limit only trips on a hang
   initial begin
      repeat (200000) @(posedge mclk_i);
      fail_count++;
      conclude;
   end
endmodule
